/* verilog/cfr_pkg.sv */
// Package for the CAN FD control and status register bank.
// Assumes one 200 MHz clock and a 32-bit Avalon-MM slave port.
package cfr_pkg;

  // ----------------------------------------------------------------
  // Register word offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_IO_PIN_CONTROL       = 5'h00;
  localparam logic [4:0] OFS_COMMAND_CHECK_STATUS = 5'h04;
  localparam logic [4:0] OFS_RAM_PROTECT_CONTROL  = 5'h08;
  localparam logic [4:0] OFS_RAM_PROTECT_STATUS   = 5'h0C;
  localparam logic [4:0] OFS_CAN_MODULE_CONTROL   = 5'h10;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int IO_PM1      = 25;
  localparam int IO_PM0      = 24;
  localparam int IO_GP1_OUTPUT_LATCH     = 9;
  localparam int IO_GP0_OUTPUT_LATCH     = 8;
  localparam int IO_STBY_EN  = 6;
  localparam int IO_DIR1     = 1;
  localparam int IO_DIR0     = 0;
  localparam int CK_FMT_IE   = 25;
  localparam int CK_SUM_IE   = 24;
  localparam int CK_FMT_F    = 17;
  localparam int CK_SUM_F    = 16;
  localparam int RP_PAR_LO   = 8;
  localparam int RP_DED_IE   = 2;
  localparam int RP_SEC_IE   = 1;
  localparam int RP_EN       = 0;
  localparam int RS_ADDR_LO  = 16;
  localparam int RS_DED_F    = 2;
  localparam int RS_SEC_F    = 1;
  localparam int CC_BWS_LO   = 28;
  localparam int CC_ABORT    = 27;
  localparam int CC_REQ_LO   = 24;
  localparam int CC_STAT_LO  = 21;
  localparam int CC_TXQ      = 20;
  localparam int CC_TX_EVENT_STORE_ENABLE     = 19;
  localparam int CC_SERR     = 18;
  localparam int CC_GATEWAY_ESI_MODE    = 17;
  localparam int CC_RTX      = 16;
  localparam int CC_RATE_SWITCH_DISABLE   = 12;
  localparam int CC_BUSY     = 11;
  localparam int CC_WFT_LO   = 9;
  localparam int CC_WAKE_LINE_FILTER_ENABLE   = 8;
  localparam int CC_PXE      = 6;
  localparam int CC_ISOCRC   = 5;
  localparam int CC_NET_LO   = 0;

  // ----------------------------------------------------------------
  // Writable masks and reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] IO_RST      = 32'h0300_0003;
  localparam logic [31:0] IO_WMASK    = 32'h0300_0343;
  localparam logic [31:0] RP_WMASK    = 32'h0000_7F07;
  // Configuration-only bits of the control word
  localparam logic [31:0] CC_CFG_MASK = 32'h001F_017F;
  localparam logic [31:0] CC_ANY_MASK = 32'hFF00_1600;
  localparam logic [31:0] CC_RST      = 32'h0498_0760;

  // ----------------------------------------------------------------
  // Operating modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_NORMAL_FD  = 3'h0,
    MODE_SLEEP      = 3'h1,
    MODE_INT_LOOP   = 3'h2,
    MODE_LISTEN     = 3'h3,
    MODE_CONFIG     = 3'h4,
    MODE_EXT_LOOP   = 3'h5,
    MODE_CLASSIC    = 3'h6,
    MODE_RESTRICTED = 3'h7
  } cfr_mode_e;

  // Abort sequencer states
  typedef enum logic [1:0] {
    AB_IDLE = 2'b01,
    AB_WAIT = 2'b10
  } cfr_abort_e;

  // Controls to the CAN core
  typedef struct packed {
    logic       tx_queue_enable;
    logic       tx_event_store_enable;
    logic       gateway_esi_mode;
    logic       limit_retransmissions;
    logic       rate_switch_disable;
    logic [1:0] wake_filter_time;
    logic       wake_line_filter_enable;
    logic       protocol_exception_disable;
    logic       standard_fd_checksum_enable;
    logic       abort_all_tx;
    logic [2:0] mode;
  } cfr_core_ctrl_s;

  // Events and state from the CAN core and RAM
  typedef struct packed {
    logic        cmd_format_err;
    logic        checksum_err;
    logic [15:0] checksum_rx;
    logic        ram_double_err;
    logic        ram_single_fix;
    logic [11:0] ram_addr;
    logic        abort_done;
    logic        busy;
    logic        system_error;
  } cfr_core_stat_s;

  // Whole module state
  typedef struct packed {
    logic [31:0]    io;
    logic [31:0]    ck;
    logic [31:0]    rp;
    logic [31:0]    rs;
    logic [31:0]    cc;
    cfr_abort_e     ab;
    logic [31:0]    rdata;
    logic           rvalid;
    logic           wait_n;
    logic [1:0]     gp_out;
    logic [1:0]     gp_oe_n;
    logic           stby_out;
    logic           stby_oe_n;
    logic           irq_cmd;
    logic           irq_ram;
    logic [6:0]     ram_parity;
    logic           ram_ecc_en;
    cfr_core_ctrl_s ctrl;
  } cfr_state_s;

endpackage : cfr_pkg

/* verilog/cfr_regs.sv */
// Control and status register bank of a CAN FD controller.
// Assumes an Avalon-MM master on core_clk and a CAN core that
// reports events as one-cycle pulses.
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - GP pin driven high or low from its output latch bits 9 and 8.
// - Standby pin controlled only while enable bit 6 is set.
// - Direction 1 is input, 0 output; mode select 0 forces output.
// - Checksum mismatch captures 16-bit received value, reset zero.
// - Bit 0 enables RAM correction; off, parity field goes to RAM.
// - Separate enables for double error and single fix interrupts.
// - Three-bit mode status reports current mode, config at reset.
// - Configuration-only bits change only in configuration mode.
// - Queue enable bit 20 enables transmit queue.
// - Event-store bit 19 saves transmitted messages.
// - System error goes to listen-only if bit 18, else restricted.
// - Bit 17 selects gateway ESI behaviour.
// - Bit 16 limits retransmissions using FIFO attempt setting.
// - Bit 12 disables bit rate switching regardless of message.
// - Busy bit 11 shows module transmitting or receiving.
// - Bit 8 enables wake filter, bits 10-9 pick its time.
// - Bit 6 makes protocol exception a form error.
// - Bit 5 selects standard FD checksum with stuff count.
module cfr_regs
  import cfr_pkg::*;
(
  // Clock and reset
  input  wire logic           core_clk,
  input  wire logic           rst,
  // Avalon-MM slave
  input  wire logic [4:0]     avs_address,
  input  wire logic           avs_read,
  input  wire logic           avs_write,
  input  wire logic [31:0]    avs_writedata,
  input  wire logic [3:0]     avs_byteenable,
  output logic [31:0]         avs_readdata,
  output logic                avs_readdatavalid,
  output logic                avs_waitrequest,
  // General purpose pins
  input  wire logic [1:0]     gp_in,
  output logic [1:0]          gp_out,
  output logic [1:0]          gp_oe_n,
  // Transceiver standby pin
  input  wire logic           stby_req,
  output logic                transceiver_standby_pin,
  output logic                stby_oe_n,
  // Interrupt requests to the pin logic
  output logic                irq_cmd,
  output logic                irq_ram,
  // RAM protection
  output logic [6:0]          ram_parity,
  output logic                ram_ecc_en,
  // CAN core
  input  wire cfr_core_stat_s core_stat,
  output cfr_core_ctrl_s      core_ctrl
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] be_mask(input logic [3:0] be);
    be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : be_mask

  function automatic logic [31:0] merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [31:0] msk
  );
    merge = (old_v & ~msk) | (new_v & msk);
  endfunction : merge

  // Sticky flag: set wins, clear by writing zero
  function automatic logic sticky(
    input logic cur,
    input logic set,
    input logic wr,
    input logic wbit
  );
    sticky = set | (cur & ~(wr & ~wbit));
  endfunction : sticky

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  cfr_state_s s_q;
  cfr_state_s s_d;

  logic [31:0] wm;
  logic        acc;
  logic        wr;
  logic        wr_io;
  logic        wr_ck;
  logic        wr_rp;
  logic        wr_rs;
  logic        wr_cc;
  logic        in_cfg;
  logic [2:0]  cur_mode;
  logic [2:0]  req_mode;
  logic [31:0] cc_m;

  always_comb
  begin
    s_d      = s_q;
    wm       = be_mask(avs_byteenable);
    acc      = (avs_read | avs_write) & s_q.wait_n;
    wr       = avs_write & acc;
    wr_io    = wr & (avs_address == OFS_IO_PIN_CONTROL);
    wr_ck    = wr & (avs_address == OFS_COMMAND_CHECK_STATUS);
    wr_rp    = wr & (avs_address == OFS_RAM_PROTECT_CONTROL);
    wr_rs    = wr & (avs_address == OFS_RAM_PROTECT_STATUS);
    wr_cc    = wr & (avs_address == OFS_CAN_MODULE_CONTROL);
    cur_mode = s_q.cc[CC_STAT_LO +: 3];
    req_mode = s_q.cc[CC_REQ_LO +: 3];
    in_cfg   = (cur_mode == MODE_CONFIG);

    // --------------------------------------------------------------
    // Bus handshake: one wait cycle, then answer
    // --------------------------------------------------------------
    s_d.wait_n = (avs_read | avs_write) & ~s_q.wait_n;
    s_d.rvalid = avs_read & acc;
    if (avs_read & acc)
    begin
      unique case (avs_address)
        OFS_IO_PIN_CONTROL:       s_d.rdata = s_q.io;
        OFS_COMMAND_CHECK_STATUS: s_d.rdata = s_q.ck;
        OFS_RAM_PROTECT_CONTROL:  s_d.rdata = s_q.rp;
        OFS_RAM_PROTECT_STATUS:   s_d.rdata = s_q.rs;
        OFS_CAN_MODULE_CONTROL:   s_d.rdata = s_q.cc;
        default:                  s_d.rdata = 32'h0000_0000;
      endcase
    end

    // --------------------------------------------------------------
    // Pin control register
    // --------------------------------------------------------------
    if (wr_io)
    begin
      s_d.io = merge(s_q.io, avs_writedata, wm & IO_WMASK);
    end
    // Input level shown in bits 17:16
    s_d.io[IO_GP0_OUTPUT_LATCH + 8 +: 2] = gp_in;

    // --------------------------------------------------------------
    // Command check register
    // --------------------------------------------------------------
    if (wr_ck)
    begin
      s_d.ck[CK_FMT_IE] = wm[CK_FMT_IE] ? avs_writedata[CK_FMT_IE]
                                        : s_q.ck[CK_FMT_IE];
      s_d.ck[CK_SUM_IE] = wm[CK_SUM_IE] ? avs_writedata[CK_SUM_IE]
                                        : s_q.ck[CK_SUM_IE];
    end
    s_d.ck[CK_FMT_F] = sticky(s_q.ck[CK_FMT_F], core_stat.cmd_format_err,
                              wr_ck & wm[CK_FMT_F],
                              avs_writedata[CK_FMT_F]);
    s_d.ck[CK_SUM_F] = sticky(s_q.ck[CK_SUM_F], core_stat.checksum_err,
                              wr_ck & wm[CK_SUM_F],
                              avs_writedata[CK_SUM_F]);
    if (core_stat.checksum_err)
    begin
      s_d.ck[15:0] = core_stat.checksum_rx;
    end

    // --------------------------------------------------------------
    // RAM protection registers
    // --------------------------------------------------------------
    // enable and parity writable
    if (wr_rp)
    begin
      s_d.rp = merge(s_q.rp, avs_writedata, wm & RP_WMASK);
    end
    s_d.rs[RS_DED_F] = sticky(s_q.rs[RS_DED_F], core_stat.ram_double_err,
                              wr_rs & wm[RS_DED_F],
                              avs_writedata[RS_DED_F]);
    s_d.rs[RS_SEC_F] = sticky(s_q.rs[RS_SEC_F], core_stat.ram_single_fix,
                              wr_rs & wm[RS_SEC_F],
                              avs_writedata[RS_SEC_F]);
    if (core_stat.ram_double_err | core_stat.ram_single_fix)
    begin
      s_d.rs[RS_ADDR_LO +: 12] = core_stat.ram_addr;
    end

    // --------------------------------------------------------------
    // CAN module control word
    // --------------------------------------------------------------
    // configuration-only bits gated by mode
    cc_m = wm & (CC_ANY_MASK | (in_cfg ? CC_CFG_MASK : 32'h0000_0000));
    if (wr_cc)
    begin
      s_d.cc = merge(s_q.cc, avs_writedata, cc_m);
    end
    unique case (s_q.ab)
      AB_IDLE:
        if (s_q.cc[CC_ABORT])
        begin
          s_d.ab = AB_WAIT;
        end
      AB_WAIT:
        if (core_stat.abort_done)
        begin
          s_d.cc[CC_ABORT] = 1'b0;
          s_d.ab           = AB_IDLE;
        end
      default:
        s_d.ab = AB_IDLE;
    endcase
    if (core_stat.system_error)
    begin
      s_d.cc[CC_REQ_LO +: 3] = s_q.cc[CC_SERR] ? MODE_LISTEN
                                               : MODE_RESTRICTED;
    end
    // status follows request one cycle later
    s_d.cc[CC_STAT_LO +: 3] = req_mode;
    s_d.cc[CC_BUSY] = core_stat.busy;

    // --------------------------------------------------------------
    // Pins and outputs
    // --------------------------------------------------------------
    // latch drives pin level
    s_d.gp_out = {s_q.io[IO_GP1_OUTPUT_LATCH], s_q.io[IO_GP0_OUTPUT_LATCH]};
    // input only with pin mode selected
    s_d.gp_oe_n = {s_q.io[IO_PM1] & s_q.io[IO_DIR1],
                   s_q.io[IO_PM0] & s_q.io[IO_DIR0]};
    s_d.stby_out  = s_q.io[IO_STBY_EN] & stby_req;
    s_d.stby_oe_n = ~s_q.io[IO_STBY_EN];
    s_d.irq_cmd = (s_q.ck[CK_FMT_IE] & s_q.ck[CK_FMT_F]) |
                  (s_q.ck[CK_SUM_IE] & s_q.ck[CK_SUM_F]);
    s_d.irq_ram = (s_q.rp[RP_DED_IE] & s_q.rs[RS_DED_F]) |
                  (s_q.rp[RP_SEC_IE] & s_q.rs[RS_SEC_F]);
    // parity used when correction is off
    s_d.ram_ecc_en = s_q.rp[RP_EN];
    s_d.ram_parity = s_q.rp[RP_PAR_LO +: 7];
    s_d.ctrl.tx_queue_enable = s_q.cc[CC_TXQ];
    s_d.ctrl.tx_event_store_enable = s_q.cc[CC_TX_EVENT_STORE_ENABLE];
    s_d.ctrl.gateway_esi_mode = s_q.cc[CC_GATEWAY_ESI_MODE];
    s_d.ctrl.limit_retransmissions = s_q.cc[CC_RTX];
    s_d.ctrl.rate_switch_disable = s_q.cc[CC_RATE_SWITCH_DISABLE];
    s_d.ctrl.wake_filter_time        = s_q.cc[CC_WFT_LO +: 2];
    s_d.ctrl.wake_line_filter_enable = s_q.cc[CC_WAKE_LINE_FILTER_ENABLE];
    s_d.ctrl.protocol_exception_disable = s_q.cc[CC_PXE];
    s_d.ctrl.standard_fd_checksum_enable = s_q.cc[CC_ISOCRC];
    s_d.ctrl.abort_all_tx = s_q.cc[CC_ABORT];
    s_d.ctrl.mode         = cur_mode;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s_q            <= '0;
      s_q.io         <= IO_RST;
      s_q.cc         <= CC_RST;
      s_q.ab         <= AB_IDLE;
      s_q.gp_oe_n    <= 2'h0;
      s_q.stby_oe_n  <= 1'b1;
      s_q.ctrl.mode  <= MODE_CONFIG;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign avs_readdata            = s_q.rdata;
  assign avs_readdatavalid       = s_q.rvalid;
  assign avs_waitrequest         = ~s_q.wait_n;
  assign gp_out                  = s_q.gp_out;
  assign gp_oe_n                 = s_q.gp_oe_n;
  assign transceiver_standby_pin = s_q.stby_out;
  assign stby_oe_n               = s_q.stby_oe_n;
  assign irq_cmd                 = s_q.irq_cmd;
  assign irq_ram                 = s_q.irq_ram;
  assign ram_parity              = s_q.ram_parity;
  assign ram_ecc_en              = s_q.ram_ecc_en;
  assign core_ctrl               = s_q.ctrl;

endmodule : cfr_regs

`default_nettype wire

/* sim/cfr_regs_asserts.sv */
// Checker for the control register bank, bound by the testbench.
// Assumes full Avalon handshake and a core that pulses its events.
`timescale 1ns/10ps
`default_nettype none
module cfr_regs_chk
  import cfr_pkg::*;
(
  // Clock and reset
  input wire logic           core_clk,
  input wire logic           rst,
  // Bus
  input wire logic [4:0]     avs_address,
  input wire logic           avs_read,
  input wire logic           avs_write,
  input wire logic [31:0]    avs_writedata,
  input wire logic [3:0]     avs_byteenable,
  input wire logic           avs_readdatavalid,
  input wire logic           avs_waitrequest,
  // Pins and core
  input wire logic           stby_req,
  input wire logic [1:0]     gp_out,
  input wire logic [1:0]     gp_oe_n,
  input wire logic           transceiver_standby_pin,
  input wire logic           stby_oe_n,
  input wire logic [6:0]     ram_parity,
  input wire logic           ram_ecc_en,
  input wire cfr_core_stat_s core_stat,
  input wire cfr_core_ctrl_s core_ctrl
);
  // ----
  // Shadow of written registers
  // ----
  logic [31:0] io_q;
  logic [31:0] rp_q;
  logic        rst_q;
  logic [31:0] be_m;
  logic        wr_ok;
  assign be_m = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                 {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wr_ok = avs_write && !avs_waitrequest;
  always_ff @(posedge core_clk)
  begin
    rst_q <= rst;
    if (rst)
    begin
      io_q <= IO_RST;
      rp_q <= '0;
    end
    else if (wr_ok && avs_address == OFS_IO_PIN_CONTROL)
      io_q <= (io_q & ~(IO_WMASK & be_m)) | (avs_writedata & IO_WMASK & be_m);
    else if (wr_ok && avs_address == OFS_RAM_PROTECT_CONTROL)
      rp_q <= (rp_q & ~(RP_WMASK & be_m)) | (avs_writedata & RP_WMASK & be_m);
  end
  // ----
  // Properties
  // ----
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_rd;
    avs_read && !avs_waitrequest;
  endsequence
  rd_valid_a: assert property (s_rd |=> avs_readdatavalid)
    else $error("read accepted without data pulse");
  wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  gp_level_a: assert property (gp_out == $past(io_q[9:8]))
    else $error("pin level differs from latch");
  stby_ctl_a: assert property ((stby_oe_n == !$past(io_q[6])) &&
    (transceiver_standby_pin == (!stby_oe_n && $past(stby_req))))
    else $error("standby pin not gated by enable");
  gp_dir_a: assert property (disable iff (rst || rst_q)
    gp_oe_n == ($past(io_q[25:24]) & $past(io_q[1:0])))
    else $error("pin direction wrong");
  ecc_out_a: assert property (disable iff (rst || rst_q)
    ram_ecc_en == $past(rp_q[0]) && ram_parity == $past(rp_q[14:8]))
    else $error("ram protection outputs wrong");
  abort_clr_a: assert property (core_ctrl.abort_all_tx &&
    core_stat.abort_done |-> ##[1:2] !core_ctrl.abort_all_tx)
    else $error("abort not cleared");
  mode_rst_a: assert property ($fell(rst) |->
    core_ctrl.mode == MODE_CONFIG)
    else $error("mode not configuration after reset");
  syserr_a: assert property (core_stat.system_error |-> ##[1:3]
    core_ctrl.mode inside {MODE_LISTEN, MODE_RESTRICTED})
    else $error("system error did not change mode");
endmodule : cfr_regs_chk
`default_nettype wire

/* sim/cfr_core_model.sv */
// Behavioural model of the CAN core behind the register bank.
// Assumes the bench calls fire for one-cycle events.
`timescale 1ns/10ps
`default_nettype none
module cfr_core_model
  import cfr_pkg::*;
(
  // Clock and reset
  input wire logic           core_clk,
  input wire logic           rst,
  // Core side
  input wire cfr_core_ctrl_s core_ctrl,
  output cfr_core_stat_s     core_stat,
  // Bench settings
  input wire logic [3:0]     abort_lag,
  input wire logic           busy
);
  logic [3:0] cnt;
  logic       sent;
  initial core_stat = '0;
  always @(posedge core_clk)
  begin
    core_stat.busy <= busy;
    core_stat.abort_done <= 1'b0;
    if (rst || !core_ctrl.abort_all_tx)
    begin
      cnt <= '0;
      sent <= 1'b0;
    end
    else if (!sent && cnt == abort_lag)
    begin
      core_stat.abort_done <= 1'b1;
      sent <= 1'b1;
    end
    else
      cnt <= cnt + 4'h1;
  end
  // One-hot event; data inverted once released
  task automatic fire(input logic [4:0] k, input logic [15:0] v);
    @(posedge core_clk);
    {core_stat.cmd_format_err, core_stat.checksum_err,
     core_stat.ram_double_err, core_stat.ram_single_fix,
     core_stat.system_error} <= k;
    core_stat.checksum_rx <= v;
    core_stat.ram_addr <= v[11:0];
    @(posedge core_clk);
    {core_stat.cmd_format_err, core_stat.checksum_err,
     core_stat.ram_double_err, core_stat.ram_single_fix,
     core_stat.system_error} <= 5'h00;
    core_stat.checksum_rx <= ~v;
    core_stat.ram_addr <= ~v[11:0];
  endtask : fire
endmodule : cfr_core_model
`default_nettype wire

/* sim/testbench.sv */
// Self-checking bench for the control register bank.
// Drives the Avalon port and the core model; checker bound below.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import cfr_pkg::*;
  logic           core_clk, rst, avs_read, avs_write, stby_req, busy;
  logic [4:0]     avs_address;
  logic [31:0]    avs_writedata, avs_readdata, io_e, cc_m, r;
  logic [3:0]     avs_byteenable, abort_lag;
  logic           avs_readdatavalid, avs_waitrequest, stby_pin, stby_oe_n;
  logic           irq_cmd, irq_ram, ram_ecc_en;
  logic [1:0]     gp_in, gp_out, gp_oe_n;
  logic [6:0]     ram_parity;
  logic [15:0]    v;
  cfr_core_stat_s core_stat;
  cfr_core_ctrl_s core_ctrl;
  logic [31:0]    exp_q[$];
  int             err_total, samples_checked;

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  cfr_regs u_dut (.core_clk(core_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_readdatavalid(avs_readdatavalid),
    .avs_waitrequest(avs_waitrequest), .gp_in(gp_in), .gp_out(gp_out),
    .gp_oe_n(gp_oe_n), .stby_req(stby_req),
    .transceiver_standby_pin(stby_pin), .stby_oe_n(stby_oe_n),
    .irq_cmd(irq_cmd), .irq_ram(irq_ram), .ram_parity(ram_parity),
    .ram_ecc_en(ram_ecc_en), .core_stat(core_stat), .core_ctrl(core_ctrl));
  cfr_core_model u_core (.core_clk(core_clk), .rst(rst),
    .core_ctrl(core_ctrl), .core_stat(core_stat), .abort_lag(abort_lag),
    .busy(busy));

  // ----
  // Tasks
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude

  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    avs_byteenable <= be;
    do
    begin
      @(posedge core_clk);
    end
    while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0, 4'hF);
  endtask : rd

  task automatic wcc(input logic [31:0] w);
    logic [31:0] m;
    m = CC_ANY_MASK | ((cc_m[23:21] == 3'h4) ? CC_CFG_MASK : 32'h0);
    wr(OFS_CAN_MODULE_CONTROL, w);
    cc_m = (cc_m & ~m) | (w & m);
    cc_m[23:21] = cc_m[26:24];
  endtask : wcc

  task automatic rcc;
    rd(OFS_CAN_MODULE_CONTROL, cc_m | (32'(busy) << 11));
    repeat (2) @(posedge core_clk);
    chk(32'(core_ctrl), 32'({cc_m[20:19], cc_m[17:16], cc_m[12],
      cc_m[10:8], cc_m[6:5], cc_m[27], cc_m[23:21]}));
  endtask : rcc

  // Read data checked against the oldest note
  always @(posedge core_clk)
    if (avs_readdatavalid === 1'b1)
      chk(avs_readdata, exp_q.size() ? exp_q.pop_front() : 32'hDEAD_BEEF);

  initial
  begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    conclude();
  end

  // ----
  // Main sequence
  // ----
  initial
  begin
    err_total = 0;
    samples_checked = 0;
    rst = 1'b1;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    avs_byteenable = 4'hF;
    {gp_in, stby_req, busy, abort_lag} = '0;
    void'($urandom(32'h222710b3));
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    gp_in <= 2'($urandom);
    io_e = IO_RST;
    cc_m = CC_RST;
    repeat (3) @(posedge core_clk);
    rd(OFS_IO_PIN_CONTROL, io_e | (32'(gp_in) << 16));
    rd(OFS_COMMAND_CHECK_STATUS, 32'h0);
    rd(OFS_RAM_PROTECT_CONTROL, 32'h0);
    rd(OFS_RAM_PROTECT_STATUS, 32'h0);
    rcc();
    wr(5'h14, $urandom);
    rd(5'h14, 32'h0);
    $display("Test reset values done");
    repeat (8)
    begin
      r = $urandom;
      stby_req <= r[31];
      gp_in <= r[17:16];
      wr(OFS_IO_PIN_CONTROL, r);
      io_e = r & IO_WMASK;
      repeat (3) @(posedge core_clk);
      chk({26'h0, gp_oe_n, gp_out, stby_oe_n, stby_pin},
          {26'h0, r[25:24] & r[1:0], r[9:8], !r[6], r[6] & r[31]});
      rd(OFS_IO_PIN_CONTROL, io_e | (32'(gp_in) << 16));
    end
    $display("Test pin control done");
    v = 16'($urandom);
    u_core.fire(5'h08, v);
    u_core.fire(5'h10, ~v);
    rd(OFS_COMMAND_CHECK_STATUS, 32'h0003_0000 | 32'(v));
    wr(OFS_COMMAND_CHECK_STATUS, 32'h0303_FFFF);
    repeat (2) @(posedge core_clk);
    chk(32'(irq_cmd), 32'h1);
    rd(OFS_COMMAND_CHECK_STATUS, 32'h0303_0000 | 32'(v));
    wr(OFS_COMMAND_CHECK_STATUS, 32'h0100_0000);
    repeat (2) @(posedge core_clk);
    chk(32'(irq_cmd), 32'h0);
    rd(OFS_COMMAND_CHECK_STATUS, 32'h0100_0000 | 32'(v));
    $display("Test command check done");
    r = $urandom;
    bus(1'b1, OFS_RAM_PROTECT_CONTROL, r, 4'h2);
    rd(OFS_RAM_PROTECT_CONTROL, r & RP_WMASK & 32'h0000_FF00);
    chk({24'h0, ram_parity, ram_ecc_en}, {24'h0, r[14:8], 1'b0});
    wr(OFS_RAM_PROTECT_CONTROL, 32'h0000_0004);
    u_core.fire(5'h04, v);
    repeat (2) @(posedge core_clk);
    chk(32'(irq_ram), 32'h1);
    u_core.fire(5'h02, ~v);
    rd(OFS_RAM_PROTECT_STATUS, {4'h0, ~v[11:0], 16'h0006});
    wr(OFS_RAM_PROTECT_STATUS, 32'h0000_0002);
    repeat (2) @(posedge core_clk);
    chk(32'(irq_ram), 32'h0);
    rd(OFS_RAM_PROTECT_STATUS, {4'h0, ~v[11:0], 16'h0002});
    $display("Test ram protection done");
    busy <= 1'b1;
    wcc(($urandom & 32'hF0FF_FFFF) | 32'h0400_0000);
    rcc();
    for (int m = 0; m < 8; m++)
    begin
      wcc({cc_m[31:27], 3'(m), cc_m[23:0]} ^ CC_CFG_MASK);
      rcc();
    end
    abort_lag <= 4'h8;
    wcc(cc_m | 32'h0800_0000);
    rcc();
    repeat (20) @(posedge core_clk);
    cc_m[27] = 1'b0;
    rcc();
    for (int s = 0; s < 2; s++)
    begin
      wcc({cc_m[31:27], 3'h4, cc_m[23:0]});
      wcc({cc_m[31:27], 3'h0, cc_m[23:19], 1'(1 - s), cc_m[17:0]});
      u_core.fire(5'h01, v);
      repeat (4) @(posedge core_clk);
      cc_m[26:21] = (s == 0) ? 6'h1B : 6'h3F;
      rcc();
    end
    $display("Test control word done");
    repeat (5) @(posedge core_clk);
    conclude();
  end
endmodule : testbench

bind cfr_regs cfr_regs_chk u_chk (.core_clk(core_clk), .rst(rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdatavalid(avs_readdatavalid),
  .avs_waitrequest(avs_waitrequest), .stby_req(stby_req), .gp_out(gp_out),
  .gp_oe_n(gp_oe_n), .transceiver_standby_pin(transceiver_standby_pin),
  .stby_oe_n(stby_oe_n), .ram_parity(ram_parity), .ram_ecc_en(ram_ecc_en),
  .core_stat(core_stat), .core_ctrl(core_ctrl));
`default_nettype wire
